/* logic/cpu_side_map.svh */
// register offsets, field positions, vector indices and reset values of the console-facing controller
`ifndef CPU_SIDE_MAP_SVH
`define CPU_SIDE_MAP_SVH

// =====================================================================
// software register offsets
`define CTRL_ADDR        8'h00
`define STATUS_ADDR      8'h04
`define PSW_ADDR         8'h08
`define PC_ADDR          8'h0C
`define VEC_BASE_ADDR    8'h10
`define VEC_ADDR_MASK    8'hF0

// =====================================================================
// control register fields
`define CTRL_REBOOT_BIT  0
`define CTRL_AUX_BIT     1

// =====================================================================
// status register fields
`define STAT_HELD_BIT    0
`define STAT_INHIBIT_BIT 1
`define STAT_ALLOW_BIT   2
`define STAT_RUN_BIT     3
`define STAT_BOOT_BIT    4
`define STAT_AC_LOW_BIT  5

// =====================================================================
// vector table indices: bit 1 picks the bootstrap space, bit 0 picks pc over psw
`define VEC_PSW_IDX      1'b0
`define VEC_PC_IDX       1'b1

// =====================================================================
// reset values
`define PIN_RESET        4'hB // sync reset: ac seen low so power-up waits for the pin, others idle high
`define DATA_ZERO        16'h0000

`endif

/* logic/cpu_side_pkg.sv */
// types shared by the console-facing controller, the console model and the testbench
package cpu_side_pkg;

    // pins seen from the console, all active low
    typedef struct packed {
        logic boot_switch_n;
        logic ac_power_low_n;
        logic selection_ack_n;
        logic halt_request_n;
    } console_in_type;

    // pins driven toward the console and bootstrap unit
    typedef struct packed {
        logic halt_grant;
        logic boot_allow_n;
        logic clock_inhibit;
    } cpu_out_type;

    typedef enum logic [2:0] {
        PWR_OFF,
        PWR_FETCH_PSW,
        PWR_WAIT_PSW,
        PWR_WAIT_PC,
        PWR_RUN
    } power_state_type;

    typedef enum logic [1:0] {
        HLT_RUN,
        HLT_INHIBIT,
        HLT_GRANT,
        HLT_HELD
    } halt_state_type;

endpackage

/* logic/vector_mem.sv */
// small vector table: one write port, one read port with registered data
`timescale 1ns/1ps
module vector_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read port
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] rd_data_reg;

    // storage, no reset on the array
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // registered read data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= mem_reg[rd_addr];
        end
    end

    assign rd_data = rd_data_reg;

endmodule // vector_mem

/* logic/cpu_side_ctrl.sv */
// processor and supply side controller facing the operator console pins
// Function
// - supply holds boot_allow_n asserted until ac_power_low_n returns high.
// - power-up starts on ac_power_low_n high; boot enabled means vectors from ROM.
// - processor answers asserted halt_request_n with halt_grant high.
// - halt_grant sets ack_hold_ff; processor stays halted while selection_ack_n low.
// - processor inhibits clock before grant, drops grant once selection_ack_n asserted.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "cpu_side_map.svh"
module cpu_side_ctrl #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    // console pins
    input  wire cpu_side_pkg::console_in_type console_in,
    output cpu_side_pkg::cpu_out_type         cpu_out,
    // software register port
    input  wire logic [ADDR_W-1:0]            addr,
    input  wire logic [DATA_W-1:0]            wr_data,
    input  wire logic                         wr_en,
    input  wire logic                         rd_en,
    output logic      [DATA_W-1:0]            rd_data
);

    // =====================================================================
    // pin synchronisers
    logic [3:0] pin_raw;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;
    logic [3:0] pin_reg;
    logic [3:0] pin_next;
    localparam logic [3:0] SYNC_RESET = `PIN_RESET;

    assign pin_raw = console_in;

    // three synchroniser flops and an output flop per pin; a change counts once the second and third agree
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_comb begin
            pin_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : pin_reg[i];
        end

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                sync1_reg[i] <= SYNC_RESET[i];
                sync2_reg[i] <= SYNC_RESET[i];
                sync3_reg[i] <= SYNC_RESET[i];
                pin_reg[i]   <= SYNC_RESET[i];
            end else begin
                sync1_reg[i] <= pin_raw[i];
                sync2_reg[i] <= sync1_reg[i];
                sync3_reg[i] <= sync2_reg[i];
                pin_reg[i]   <= pin_next[i];
            end
        end
    end

    cpu_side_pkg::console_in_type pins;
    logic                         halt_req_low;
    logic                         sack_low;
    logic                         ac_low;
    logic                         boot_sw_low;

    assign pins         = pin_reg;
    assign halt_req_low = !pins.halt_request_n;
    assign sack_low     = !pins.selection_ack_n;
    assign ac_low       = !pins.ac_power_low_n;
    assign boot_sw_low  = !pins.boot_switch_n;

    // =====================================================================
    // software registers
    logic              reboot_enable_reg;
    logic              reboot_enable_next;
    logic              aux_lost_pulse;
    logic              ctrl_hit;
    logic              vec_hit;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] psw_reg;
    logic [DATA_W-1:0] psw_next;
    logic [DATA_W-1:0] pc_reg;
    logic [DATA_W-1:0] pc_next;

    assign ctrl_hit       = wr_en && (addr == `CTRL_ADDR);
    assign vec_hit        = wr_en && ((addr & `VEC_ADDR_MASK) == `VEC_BASE_ADDR);
    assign aux_lost_pulse = ctrl_hit && wr_data[`CTRL_AUX_BIT];

    // =====================================================================
    // supply side boot allow hold
    logic boot_allow_reg;
    logic boot_allow_next;

    // hold boot allow: raised on aux loss, released once ac returns high
    always_comb begin
        boot_allow_next = boot_allow_reg;
        if (!ac_low) begin
            boot_allow_next = 1'b0;
        end
        if (aux_lost_pulse) begin
            boot_allow_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_allow_reg <= 1'b0;
        end else begin
            boot_allow_reg <= boot_allow_next;
        end
    end

    // =====================================================================
    // power-up sequencer
    cpu_side_pkg::power_state_type pwr_state_reg;
    cpu_side_pkg::power_state_type pwr_state_next;
    logic                          boot_sel_reg;
    logic                          boot_sel_next;
    logic [1:0]                    vec_rd_addr;
    logic [DATA_W-1:0]             vec_rd_data;

    // vector choice: bootstrap space when boot was enabled during power-down
    assign vec_rd_addr = (pwr_state_reg == cpu_side_pkg::PWR_FETCH_PSW) ? {boot_sel_reg, `VEC_PSW_IDX}
                                                                         : {boot_sel_reg, `VEC_PC_IDX};

    // power-up: latch boot choice, fetch psw then pc
    always_comb begin
        pwr_state_next = pwr_state_reg;
        boot_sel_next  = boot_sel_reg;
        psw_next       = psw_reg;
        pc_next        = pc_reg;
        case (pwr_state_reg)
            cpu_side_pkg::PWR_OFF: begin
                if (ac_low) begin
                    boot_sel_next = boot_sel_reg | reboot_enable_reg | boot_sw_low | boot_allow_reg;
                end else begin
                    pwr_state_next = cpu_side_pkg::PWR_FETCH_PSW;
                end
            end
            cpu_side_pkg::PWR_FETCH_PSW: begin
                pwr_state_next = cpu_side_pkg::PWR_WAIT_PSW;
            end
            cpu_side_pkg::PWR_WAIT_PSW: begin
                psw_next       = vec_rd_data;
                pwr_state_next = cpu_side_pkg::PWR_WAIT_PC;
            end
            cpu_side_pkg::PWR_WAIT_PC: begin
                pc_next        = vec_rd_data;
                pwr_state_next = cpu_side_pkg::PWR_RUN;
            end
            cpu_side_pkg::PWR_RUN: begin
                boot_sel_next = 1'b0;
            end
            default: begin
                pwr_state_next = cpu_side_pkg::PWR_OFF;
            end
        endcase
        if (ac_low && (pwr_state_reg != cpu_side_pkg::PWR_OFF)) begin
            pwr_state_next = cpu_side_pkg::PWR_OFF;
            boot_sel_next  = reboot_enable_reg | boot_sw_low | boot_allow_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_state_reg <= cpu_side_pkg::PWR_OFF;
            boot_sel_reg  <= 1'b0;
            psw_reg       <= `DATA_ZERO;
            pc_reg        <= `DATA_ZERO;
        end else begin
            pwr_state_reg <= pwr_state_next;
            boot_sel_reg  <= boot_sel_next;
            psw_reg       <= psw_next;
            pc_reg        <= pc_next;
        end
    end

    // vector table written by software, read by the sequencer
    vector_mem #(
        .WIDTH (DATA_W),
        .DEPTH (4),
        .AW    (2)
    ) u_vec (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (vec_hit),
        .wr_addr  (addr[3:2]),
        .wr_data  (wr_data),
        .rd_addr  (vec_rd_addr),
        .rd_data  (vec_rd_data)
    );

    // =====================================================================
    // halt handshake
    cpu_side_pkg::halt_state_type halt_state_reg;
    cpu_side_pkg::halt_state_type halt_state_next;
    logic                         grant_reg;
    logic                         grant_next;
    logic                         inhibit_reg;
    logic                         inhibit_next;

    // inhibit clock, then grant, hold while selection ack low
    always_comb begin
        halt_state_next = halt_state_reg;
        grant_next      = 1'b0;
        inhibit_next    = inhibit_reg;
        case (halt_state_reg)
            cpu_side_pkg::HLT_RUN: begin
                inhibit_next = 1'b0;
                if (halt_req_low && (pwr_state_reg == cpu_side_pkg::PWR_RUN)) begin
                    halt_state_next = cpu_side_pkg::HLT_INHIBIT;
                    inhibit_next    = 1'b1;
                end
            end
            cpu_side_pkg::HLT_INHIBIT: begin
                halt_state_next = cpu_side_pkg::HLT_GRANT;
                grant_next      = 1'b1;
            end
            cpu_side_pkg::HLT_GRANT: begin
                if (sack_low) begin
                    halt_state_next = cpu_side_pkg::HLT_HELD;
                end else if (!halt_req_low) begin
                    halt_state_next = cpu_side_pkg::HLT_RUN;
                    inhibit_next    = 1'b0;
                end else begin
                    grant_next = 1'b1;
                end
            end
            cpu_side_pkg::HLT_HELD: begin
                if (!sack_low) begin
                    halt_state_next = cpu_side_pkg::HLT_RUN;
                    inhibit_next    = 1'b0;
                end
            end
            default: begin
                halt_state_next = cpu_side_pkg::HLT_RUN;
                inhibit_next    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_state_reg <= cpu_side_pkg::HLT_RUN;
            grant_reg      <= 1'b0;
            inhibit_reg    <= 1'b0;
        end else begin
            halt_state_reg <= halt_state_next;
            grant_reg      <= grant_next;
            inhibit_reg    <= inhibit_next;
        end
    end

    // =====================================================================
    // register read and control write
    always_comb begin
        status_word                     = `DATA_ZERO;
        status_word[`STAT_HELD_BIT]     = (halt_state_reg == cpu_side_pkg::HLT_HELD);
        status_word[`STAT_INHIBIT_BIT]  = inhibit_reg;
        status_word[`STAT_ALLOW_BIT]    = boot_allow_reg;
        status_word[`STAT_RUN_BIT]      = (pwr_state_reg == cpu_side_pkg::PWR_RUN);
        status_word[`STAT_BOOT_BIT]     = boot_sel_reg;
        status_word[`STAT_AC_LOW_BIT]   = ac_low;
        reboot_enable_next              = ctrl_hit ? wr_data[`CTRL_REBOOT_BIT] : reboot_enable_reg;
        rd_data_next                    = `DATA_ZERO;
        if (rd_en) begin
            case (addr)
                `CTRL_ADDR:   rd_data_next[`CTRL_REBOOT_BIT] = reboot_enable_reg;
                `STATUS_ADDR: rd_data_next = status_word;
                `PSW_ADDR:    rd_data_next = psw_reg;
                `PC_ADDR:     rd_data_next = pc_reg;
                default:      rd_data_next = `DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reboot_enable_reg <= 1'b0;
            rd_data_reg       <= `DATA_ZERO;
        end else begin
            reboot_enable_reg <= reboot_enable_next;
            rd_data_reg       <= rd_data_next;
        end
    end
    // outputs straight from flops
    assign rd_data               = rd_data_reg;
    assign cpu_out.halt_grant    = grant_reg;
    assign cpu_out.boot_allow_n  = !boot_allow_reg;
    assign cpu_out.clock_inhibit = inhibit_reg;
    // =====================================================================
    // checks
    a_grant_after_inhibit: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(grant_reg) |-> inhibit_reg && $past(inhibit_reg))
        else $error("grant raised without clock inhibited first");
    a_grant_answers_req: assert property (@(posedge core_clk) disable iff (!rst_n)
        (halt_state_reg == cpu_side_pkg::HLT_RUN) && halt_req_low && (pwr_state_reg == cpu_side_pkg::PWR_RUN)
        |-> ##2 grant_reg)
        else $error("halt request not granted two cycles later");
    a_grant_drops_sack: assert property (@(posedge core_clk) disable iff (!rst_n)
        grant_reg && sack_low |=> !grant_reg [*2])
        else $error("grant kept after selection ack");
    a_allow_holds_ac: assert property (@(posedge core_clk) disable iff (!rst_n)
        boot_allow_reg && ac_low |=> boot_allow_reg)
        else $error("boot allow dropped while ac still low");
    a_allow_ends_ac: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ac_low && !aux_lost_pulse |=> !boot_allow_reg)
        else $error("boot allow held after ac high");
    a_powerup_sequence: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pwr_state_reg == cpu_side_pkg::PWR_OFF) && !ac_low ##1 !ac_low [*4]
        |-> pwr_state_reg == cpu_side_pkg::PWR_RUN)
        else $error("power-up did not finish in four cycles");
    a_boot_space_fetch: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pwr_state_reg == cpu_side_pkg::PWR_WAIT_PSW) |-> pc_next == $past(pc_reg) && psw_next == vec_rd_data
        && vec_rd_addr == {boot_sel_reg, `VEC_PC_IDX})
        else $error("vector fetch used wrong space or entry");
    a_held_no_grant: assert property (@(posedge core_clk) disable iff (!rst_n)
        (halt_state_reg == cpu_side_pkg::HLT_HELD) |-> !grant_reg && inhibit_reg)
        else $error("clock not inhibited while halted");
endmodule // cpu_side_ctrl

/* testbench/console_model.sv */
// operator console model: halt/continue and boot/init switch logic facing the processor side
`timescale 1ns/1ps
module console_model #(
    parameter int PULSE_LEN = 4, // clear pulse cycles, stands in for the rc delay
    parameter int SLOW_ACK  = 3  // extra grant cycles before ack when answering slowly
) (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    // processor side pins
    input  wire cpu_side_pkg::cpu_out_type  cpu_out,
    output cpu_side_pkg::console_in_type    console_in,
    // switches, supply and bus state
    input  wire logic                       halt_sw,
    input  wire logic                       init_sw,
    input  wire logic                       supply_ac_n,
    input  wire logic                       dc_power_low_n,
    input  wire logic                       bus_initialize_n,
    input  wire logic                       slow,
    // lamp
    output logic                            run_lamp
);
    logic       halt_request_ff;
    logic       ack_hold_ff;
    logic       init_d;
    logic [3:0] pulse_cnt;
    logic [3:0] ack_wait;

    // =========================================================
    // switch flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_request_ff <= 1'h1;
            ack_hold_ff     <= 1'h0;
            init_d          <= 1'h0;
            pulse_cnt       <= 4'h0;
            ack_wait        <= 4'h0;
        end else begin
            init_d <= init_sw;
            halt_request_ff <= !halt_sw;
            if (init_d && !init_sw) pulse_cnt <= 4'(PULSE_LEN);
            else if (pulse_cnt != 4'h0) pulse_cnt <= pulse_cnt - 4'h1;
            ack_wait <= cpu_out.halt_grant ? ack_wait + 4'h1 : 4'h0;
            if (!bus_initialize_n || pulse_cnt != 4'h0 || (!halt_request_ff && !halt_sw)) ack_hold_ff <= 1'h0;
            else if (cpu_out.halt_grant && (!slow || ack_wait >= 4'(SLOW_ACK))) ack_hold_ff <= 1'h1;
        end
    end

    // request gated by power and init
    assign console_in.halt_request_n  = !(!halt_request_ff && dc_power_low_n && bus_initialize_n);
    assign console_in.selection_ack_n = !ack_hold_ff;
    // init asserts ac low and boot switch
    assign console_in.ac_power_low_n  = supply_ac_n && !init_sw;
    assign console_in.boot_switch_n   = !init_sw;
    assign run_lamp = !ack_hold_ff;
endmodule // console_model

/* testbench/testbench.sv */
// self-checking bench for the processor side controller with a console model
`timescale 1ns/1ps
`include "cpu_side_map.svh"
module testbench;
    logic                         core_clk;
    logic                         rst_n;
    cpu_side_pkg::console_in_type console_in;
    cpu_side_pkg::cpu_out_type    cpu_out;
    logic [7:0]                   addr;
    logic [15:0]                  wr_data;
    logic                         wr_en;
    logic                         rd_en;
    logic [15:0]                  rd_data;
    logic                         halt_sw;
    logic                         init_sw;
    logic                         supply_ac_n;
    logic                         dc_power_low_n;
    logic                         bus_initialize_n;
    logic                         slow;
    logic                         run_lamp;
    logic [15:0]                  d;
    int                           err_count;
    int                           comparisons;

    cpu_side_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .console_in(console_in), .cpu_out(cpu_out),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));

    console_model model_u (.core_clk(core_clk), .rst_n(rst_n), .cpu_out(cpu_out), .console_in(console_in),
        .halt_sw(halt_sw), .init_sw(init_sw), .supply_ac_n(supply_ac_n), .dc_power_low_n(dc_power_low_n),
        .bus_initialize_n(bus_initialize_n), .slow(slow), .run_lamp(run_lamp));

    // =========================================================
    // clock
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    // =========================================================
    // helpers
    task check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge core_clk);
        wr_en   <= 1'h1;
        addr    <= a;
        wr_data <= v;
        @(posedge core_clk);
        wr_en <= 1'h0;
    endtask

    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge core_clk);
        rd_en <= 1'h1;
        addr  <= a;
        @(posedge core_clk);
        rd_en <= 1'h0;
        #1;
        v = rd_data;
    endtask

    // status polled until masked bits match, bounded
    task poll(input logic [15:0] mask, input logic [15:0] want);
        int n;
        n = 0;
        rd(`STATUS_ADDR, d);
        while ((d & mask) !== want && n < 60) begin
            rd(`STATUS_ADDR, d);
            n++;
        end
        check(d & mask, want);
    endtask

    task wait_grant(input logic val);
        int n;
        n = 0;
        while (cpu_out.halt_grant !== val && n < 60) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check({15'h0, cpu_out.halt_grant}, {15'h0, val});
    endtask

    // one power-down and power-up, by supply or by init switch
    task power_up(input logic [15:0] ctrl, input logic by_init, input logic [15:0] processor_status_word, input logic [15:0] pc);
        @(posedge core_clk);
        if (by_init) init_sw <= 1'h1;
        else supply_ac_n <= 1'h0;
        poll(16'h0020, 16'h0020);
        wr(`CTRL_ADDR, ctrl);
        #1;
        check({15'h0, cpu_out.boot_allow_n}, {15'h0, !ctrl[1]});
        rd(`STATUS_ADDR, d);
        check(d & 16'h0034, {10'h0, 1'h1, by_init | ctrl[0] | ctrl[1], 1'h0, ctrl[1], 2'h0});
        @(posedge core_clk);
        init_sw     <= 1'h0;
        supply_ac_n <= 1'h1;
        poll(16'h0028, 16'h0008);
        check({15'h0, cpu_out.boot_allow_n}, 16'h0001);
        rd(`PSW_ADDR, d);
        check(d, processor_status_word);
        rd(`PC_ADDR, d);
        check(d, pc);
    endtask

    task final_report;
        if (err_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // =========================================================
    // watchdog
    initial begin
        #300000;
        err_count++;
        final_report();
    end

    // =========================================================
    // main sequence
    initial begin
        err_count = 0;
        comparisons = 0;
        rst_n = 1'h0;
        addr = 8'h00;
        wr_data = 16'h0000;
        wr_en = 1'h0;
        rd_en = 1'h0;
        halt_sw = 1'h0;
        init_sw = 1'h0;
        supply_ac_n = 1'h0;
        dc_power_low_n = 1'h1;
        bus_initialize_n = 1'h1;
        slow = 1'h0;
        repeat (4) @(posedge core_clk);
        check({13'h0, cpu_out}, 16'h0002);
        check(rd_data, 16'h0000);
        rst_n <= 1'h1;
        // vectors: low psw, low pc, boot psw, boot pc
        wr(8'h10, 16'h00A5);
        wr(8'h14, 16'h1000);
        wr(8'h18, 16'h00E0);
        wr(8'h1C, 16'h0ABC);
        rd(8'h10, d);
        check(d, 16'h0000);
        rd(8'h20, d);
        check(d, 16'h0000);
        power_up(16'h0000, 1'h0, 16'h00A5, 16'h1000);
        power_up(16'h0001, 1'h0, 16'h00E0, 16'h0ABC);
        rd(`CTRL_ADDR, d);
        check(d, 16'h0001);
        wr(`CTRL_ADDR, 16'h0000);
        power_up(16'h0002, 1'h0, 16'h00E0, 16'h0ABC);
        rd(`CTRL_ADDR, d);
        check(d, 16'h0000);
        power_up(16'h0000, 1'h1, 16'h00E0, 16'h0ABC);
        power_up(16'h0000, 1'h0, 16'h00A5, 16'h1000);
        // halt and continue, prompt then slow console
        for (int s = 0; s < 2; s++) begin
            @(posedge core_clk);
            slow    <= 1'(s);
            halt_sw <= 1'h1;
            wait_grant(1'h1);
            check({15'h0, cpu_out.clock_inhibit}, 16'h0001);
            wait_grant(1'h0);
            check({15'h0, run_lamp}, 16'h0000);
            poll(16'h0003, 16'h0003);
            @(posedge core_clk);
            halt_sw <= 1'h0;
            poll(16'h0003, 16'h0000);
            check({15'h0, run_lamp}, 16'h0001);
        end
        // bus init frees a held processor
        @(posedge core_clk);
        slow    <= 1'h0;
        halt_sw <= 1'h1;
        wait_grant(1'h1);
        wait_grant(1'h0);
        @(posedge core_clk);
        bus_initialize_n <= 1'h0;
        poll(16'h0003, 16'h0000);
        check({15'h0, run_lamp}, 16'h0001);
        @(posedge core_clk);
        bus_initialize_n <= 1'h1;
        halt_sw          <= 1'h0;
        // dc low keeps the request off
        @(posedge core_clk);
        dc_power_low_n <= 1'h0;
        halt_sw        <= 1'h1;
        repeat (30) @(posedge core_clk);
        #1;
        check({13'h0, cpu_out}, 16'h0002);
        check({15'h0, console_in.halt_request_n}, 16'h0001);
        @(posedge core_clk);
        halt_sw        <= 1'h0;
        dc_power_low_n <= 1'h1;
        repeat (10) @(posedge core_clk);
        final_report();
    end
endmodule // testbench
